//--- cbps_checker.sv
// Port checker of the control bus pin mux.
// Bound to cbps_pin_mux; sees only its ports.
`timescale 1ns/10ps

module cbps_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic uart_sending,
    input wire logic usb_configured,
    input wire logic usb_suspend,
    input wire logic host_data_fwd,
    input wire logic port_write_strobe_n,
    input wire logic [4:0] ctrl_pin_o,
    input wire logic [3:0] ctrl_pin_oe_n
);
    logic [31:0] cfg_q, cfg_d, eff_q;
    logic up_q;

    // Shadow of the stored setting, delayed to when pins follow it
    always_comb
    begin
        cfg_d = cfg_q;
        if (psel && penable && pwrite && paddr == cbps_pkg::CFG_OFS)
            cfg_d = pwdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= cbps_pkg::CFG_RST;
            eff_q <= cbps_pkg::CFG_RST;
            up_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            eff_q <= cfg_q;
            up_q <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_rs485;
        up_q && eff_q[11:8] == 4'h0 |->
            ctrl_pin_o[2] == $past(uart_sending);
    endproperty
    property p_power;
        up_q && eff_q[15:12] == 4'h1 |-> ctrl_pin_o[3] ==
            !($past(usb_configured) && !$past(usb_suspend));
    endproperty
    property p_sleep;
        up_q && eff_q[19:16] == 4'h5 |->
            ctrl_pin_o[4] == !$past(usb_suspend);
    endproperty
    property p_led;
        up_q && eff_q[3:0] == 4'h2 && $past(host_data_fwd) |->
            ##1 !ctrl_pin_o[0] [*8];
    endproperty
    property p_wr;
        up_q && eff_q[3:0] == 4'hB |->
            ctrl_pin_o[0] == $past(port_write_strobe_n);
    endproperty
    property p_wr_bad;
        up_q && eff_q[11:8] == 4'hB |-> ctrl_pin_o[2];
    endproperty
    property p_freeze;
        up_q && $past(up_q) && eff_q[11:8] == 4'h9 &&
            $past(eff_q[11:8]) == 4'h9 && $past(usb_suspend) &&
            $past(usb_suspend, 2) |-> $stable(ctrl_pin_o[2]);
    endproperty
    property p_oe;
        up_q && eff_q[11:8] != 4'hA |-> !ctrl_pin_oe_n[2];
    endproperty

    a_rs485: assert property (p_rs485) else $error("rs485 pin");
    a_power: assert property (p_power) else $error("power pin");
    a_sleep: assert property (p_sleep) else $error("sleep pin");
    a_led: assert property (p_led) else $error("led stretch");
    a_wr: assert property (p_wr) else $error("write strobe");
    a_wr_bad: assert property (p_wr_bad) else $error("bad code");
    a_freeze: assert property (p_freeze) else $error("clock run");
    a_oe: assert property (p_oe) else $error("pin not driven");

    c_led: cover property (host_data_fwd && eff_q[3:0] == 4'h2);
    c_susp: cover property (usb_suspend && eff_q[11:8] == 4'h9);
    c_gpio: cover property (eff_q[11:8] == 4'hA && ctrl_pin_oe_n[2]);
endmodule

bind cbps_pin_mux cbps_checker u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .uart_sending, .usb_configured, .usb_suspend,
    .host_data_fwd, .port_write_strobe_n, .ctrl_pin_o, .ctrl_pin_oe_n);

//--- cbps_far_side.sv
// Far side model: external logic, pull-ups and a power switch.
// Assumes pin 3 carries the power enable when power matters.
`timescale 1ns/10ps

module cbps_far_side (
    input wire logic [4:0] ctrl_pin_o,
    input wire logic [3:0] ctrl_pin_oe_n,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] ctrl_pin_i
);
    logic [3:0] idle;

    // Undriven pins rest high, or low while external power is off
    assign idle = ctrl_pin_o[3] ? 4'h0 : 4'hF;
    assign ctrl_pin_i = (~ctrl_pin_oe_n & ctrl_pin_o[3:0])
        | (ctrl_pin_oe_n & ext_en & ext_val)
        | (ctrl_pin_oe_n & ~ext_en & idle);
endmodule

//--- cbps_pin_mux.sv
// Control bus pin function selector with APB configuration and GPIO.
// Assumes status inputs from the USB engine and UART on pclk.
`timescale 1ns/10ps

module cbps_pin_mux #(
    parameter int LED_HOLD = cbps_pkg::LED_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic uart_sending,
    input wire logic usb_configured,
    input wire logic usb_suspend,
    input wire logic host_data_fwd,
    input wire logic dev_data_fwd,
    input wire logic port_write_strobe_n,
    input wire logic port_read_strobe_n,
    input wire logic [3:0] ctrl_pin_i,
    output logic [4:0] ctrl_pin_o,
    output logic [3:0] ctrl_pin_oe_n
);

    // ------------------------------------------------------------
    // Configuration and GPIO registers
    // ------------------------------------------------------------
    logic [31:0] cfg_q, cfg_d;
    logic [3:0] gpo_q, gpo_d;
    logic [3:0] gdir_q, gdir_d;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign addr_ok = (paddr == cbps_pkg::CFG_OFS) ||
                     (paddr == cbps_pkg::GPIO_OUT_OFS) ||
                     (paddr == cbps_pkg::GPIO_DIR_OFS) ||
                     (paddr == cbps_pkg::STATUS_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_comb
    begin
        cfg_d = cfg_q;
        gpo_d = gpo_q;
        gdir_d = gdir_q;
        if (wr_en && paddr == cbps_pkg::CFG_OFS)
        begin
            cfg_d = {12'h000, pwdata[19:0]};
        end
        if (wr_en && paddr == cbps_pkg::GPIO_OUT_OFS)
        begin
            gpo_d = pwdata[3:0];
        end
        if (wr_en && paddr == cbps_pkg::GPIO_DIR_OFS)
        begin
            gdir_d = pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= cbps_pkg::CFG_RST;
            gpo_q <= cbps_pkg::GPIO_OUT_RST;
            gdir_q <= cbps_pkg::GPIO_DIR_RST;
        end
        else
        begin
            cfg_q <= cfg_d;
            gpo_q <= gpo_d;
            gdir_q <= gdir_d;
        end
    end

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    logic [3:0] s1_q, s2_q, s3_q, gin_q;
    logic [3:0] gin_d;

    always_comb
    begin
        gin_d = gin_q;
        for (int i = 0; i < 4; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                gin_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
            gin_q <= 4'h0;
        end
        else
        begin
            s1_q <= ctrl_pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            gin_q <= gin_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_d, rd_q;

    always_comb
    begin
        rd_d = rd_q;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                cbps_pkg::CFG_OFS: rd_d = cfg_q;
                cbps_pkg::GPIO_OUT_OFS: rd_d = {28'h000_0000, gpo_q};
                cbps_pkg::GPIO_DIR_OFS: rd_d = {28'h000_0000, gdir_q};
                cbps_pkg::STATUS_OFS: rd_d = {24'h00_0000, usb_suspend,
                    usb_configured, uart_sending, 1'b0, gin_q};
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_q <= 32'h0000_0000;
        end
        else
        begin
            rd_q <= rd_d;
        end
    end

    assign prdata = rd_en ? rd_q : 32'h0000_0000;

    // ------------------------------------------------------------
    // Clock divider: fast clock toggles each cycle while usb_suspend is low, others derived
    // ------------------------------------------------------------
    logic [3:0] div_q, div_d;

    always_comb
    begin
        div_d = div_q;
        if (!usb_suspend)
        begin
            div_d = div_q + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= 4'h0;
        end
        else
        begin
            div_q <= div_d;
        end
    end

    // ------------------------------------------------------------
    // LED stretchers: host-to-device, device-to-host, either
    // ------------------------------------------------------------
    localparam int LED_CNT_W_L = cbps_pkg::LED_CNT_W;
    logic [2:0] led_evt;
    logic [2:0] led_on;
    logic [LED_CNT_W_L-1:0] led_q [3];
    logic [LED_CNT_W_L-1:0] led_d [3];

    assign led_evt = {host_data_fwd || dev_data_fwd, dev_data_fwd,
                      host_data_fwd};

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            led_d[i] = led_q[i];
            if (led_evt[i])
            begin
                led_d[i] = LED_HOLD[LED_CNT_W_L-1:0];
            end
            else if (led_q[i] != '0)
            begin
                led_d[i] = led_q[i] - 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
            begin
                led_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                led_q[i] <= led_d[i];
            end
        end
    end

    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_led
            assign led_on[g] = (led_q[g] != '0);
        end
    endgenerate

    // ------------------------------------------------------------
    // Per pin function select
    // ------------------------------------------------------------
    function automatic logic fn_allowed(input logic [3:0] fn,
                                        input int pin);
        fn_allowed = 1'b1;
        if (fn == cbps_pkg::FN_GPIO || fn == cbps_pkg::FN_RD_N)
        begin
            fn_allowed = (pin < 4);
        end
        else if (fn == cbps_pkg::FN_WR_N)
        begin
            fn_allowed = (pin < 2);
        end
        else if (fn > cbps_pkg::FN_RD_N)
        begin
            fn_allowed = 1'b0;
        end
    endfunction

    function automatic logic fn_idle(input logic [3:0] fn);
        fn_idle = !(fn == cbps_pkg::FN_RS485 ||
                    (fn >= cbps_pkg::FN_CLK_FAST &&
                     fn <= cbps_pkg::FN_CLK_EIGHTH));
    endfunction

    logic [4:0] pin_d, pin_q;
    logic [3:0] oe_d, oe_q;

    always_comb
    begin
        logic [3:0] fn;
        fn = 4'h0;
        pin_d = '0;
        oe_d = 4'hF;
        for (int p = 0; p < 5; p++)
        begin
            fn = cfg_q[p*cbps_pkg::FN_W +: cbps_pkg::FN_W];
            if (!fn_allowed(fn, p))
            begin
                pin_d[p] = fn_idle(fn);
            end
            else
            begin
                case (fn)
                    cbps_pkg::FN_RS485: pin_d[p] = uart_sending;
                    cbps_pkg::FN_PWR_N:
                        pin_d[p] = usb_suspend || !usb_configured;
                    cbps_pkg::FN_HOST_TO_DEV_LED_N_N: pin_d[p] = !led_on[0];
                    cbps_pkg::FN_DEV_TO_HOST_LED_N_N: pin_d[p] = !led_on[1];
                    cbps_pkg::FN_ANYLED_N: pin_d[p] = !led_on[2];
                    cbps_pkg::FN_SLEEP_N: pin_d[p] = !usb_suspend;
                    cbps_pkg::FN_CLK_FAST: pin_d[p] = div_q[0];
                    cbps_pkg::FN_CLK_HALF: pin_d[p] = div_q[1];
                    cbps_pkg::FN_CLK_QUARTER: pin_d[p] = div_q[2];
                    cbps_pkg::FN_CLK_EIGHTH: pin_d[p] = div_q[3];
                    cbps_pkg::FN_WR_N: pin_d[p] = port_write_strobe_n;
                    cbps_pkg::FN_RD_N: pin_d[p] = port_read_strobe_n;
                    cbps_pkg::FN_GPIO:
                    begin
                        pin_d[p] = gpo_q[p[1:0]];
                        oe_d[p[1:0]] = !gdir_q[p[1:0]];
                    end
                    default: pin_d[p] = 1'b1;
                endcase
                if (p < 4 && fn != cbps_pkg::FN_GPIO)
                begin
                    oe_d[p[1:0]] = 1'b0;
                end
            end
            if (p < 4 && !fn_allowed(fn, p))
            begin
                oe_d[p[1:0]] = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_q <= 5'h1F;
            oe_q <= 4'hF;
        end
        else
        begin
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    assign ctrl_pin_o = pin_q;
    assign ctrl_pin_oe_n = oe_q;

endmodule

//--- cbps_pkg.sv
// Constants, selector codes and register map of the control bus pin mux.
// Assumes an APB master on pclk at 200 MHz and an active low async reset.
package cbps_pkg;

    // ------------------------------------------------------------
    // Function codes
    // ------------------------------------------------------------
    localparam logic [3:0] FN_RS485 = 4'h0;
    localparam logic [3:0] FN_PWR_N = 4'h1;
    localparam logic [3:0] FN_HOST_TO_DEV_LED_N_N = 4'h2;
    localparam logic [3:0] FN_DEV_TO_HOST_LED_N_N = 4'h3;
    localparam logic [3:0] FN_ANYLED_N = 4'h4;
    localparam logic [3:0] FN_SLEEP_N = 4'h5;
    localparam logic [3:0] FN_CLK_FAST = 4'h6;
    localparam logic [3:0] FN_CLK_HALF = 4'h7;
    localparam logic [3:0] FN_CLK_QUARTER = 4'h8;
    localparam logic [3:0] FN_CLK_EIGHTH = 4'h9;
    localparam logic [3:0] FN_GPIO = 4'hA;
    localparam logic [3:0] FN_WR_N = 4'hB;
    localparam logic [3:0] FN_RD_N = 4'hC;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_OFS = 12'h000;
    localparam logic [11:0] GPIO_OUT_OFS = 12'h004;
    localparam logic [11:0] GPIO_DIR_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00C;
    localparam int FN_W = 4;
    localparam logic [31:0] CFG_RST = 32'h0005_1032;
    localparam logic [3:0] GPIO_OUT_RST = 4'h0;
    localparam logic [3:0] GPIO_DIR_RST = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int LED_MS = 50;
    localparam int LED_CYCLES = LED_MS * CLK_MHZ * 1000;
    localparam int LED_CNT_W = 24;

endpackage

//--- control_bus_pin_function_select_tb_top.sv
// Directed testbench of the control bus pin mux over APB.
// Assumes the far side model and the bound checker.
`timescale 1ns/10ps

module control_bus_pin_function_select_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic uart_sending, usb_configured, usb_suspend, wr_n, rd_n;
    logic host_data_fwd, dev_data_fwd;
    logic [4:0] ctrl_pin_o;
    logic [3:0] ctrl_pin_oe_n, ctrl_pin_i, ext_en, ext_val;
    logic [15:0] exp0 = 16'h043D;
    int errors, n_checks, tog;

    cbps_pin_mux #(.LED_HOLD(20)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .uart_sending,
        .usb_configured, .usb_suspend, .host_data_fwd, .dev_data_fwd,
        .port_write_strobe_n(wr_n), .port_read_strobe_n(rd_n),
        .ctrl_pin_i, .ctrl_pin_o, .ctrl_pin_oe_n);
    cbps_far_side far (.ctrl_pin_o, .ctrl_pin_oe_n, .ext_en, .ext_val,
        .ctrl_pin_i);

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cfg(input int p, input logic [3:0] c);
        logic [31:0] v;
        v = cbps_pkg::CFG_RST;
        v[4*p+:4] = c;
        apb(1'b1, cbps_pkg::CFG_OFS, v);
    endtask

    task automatic pin(input int p, input logic e);
        wt(3);
        chk({31'h0, ctrl_pin_o[p]}, {31'h0, e});
    endtask

    task automatic cnt();
        logic prev;
        tog = 0;
        prev = ctrl_pin_o[2];
        repeat (32)
        begin
            @(posedge pclk);
            tog += (ctrl_pin_o[2] !== prev);
            prev = ctrl_pin_o[2];
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #60000;
        errors++;
        final_report();
    end

    initial
    begin
        errors = 0;
        n_checks = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {uart_sending, usb_configured, usb_suspend} = 3'h0;
        {host_data_fwd, dev_data_fwd, wr_n, rd_n} = 4'h3;
        ext_en = 4'h0;
        ext_val = 4'h0;
        wt(12);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, cbps_pkg::CFG_OFS, 32'h0);
        chk(rd, cbps_pkg::CFG_RST);
        apb(1'b1, cbps_pkg::CFG_OFS, 32'h000A_BC98);
        apb(1'b0, cbps_pkg::CFG_OFS, 32'h0);
        chk(rd, 32'h000A_BC98);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, cbps_pkg::CFG_OFS, cbps_pkg::CFG_RST);
        $display("test registers done");
        uart_sending <= 1'b1;
        usb_configured <= 1'b1;
        pin(0, 1'b1);
        chk({27'h0, ctrl_pin_o}, 32'h17);
        usb_suspend <= 1'b1;
        pin(0, 1'b1);
        chk({27'h0, ctrl_pin_o}, 32'h0F);
        usb_suspend <= 1'b0;
        host_data_fwd <= 1'b1;
        wt(1);
        host_data_fwd <= 1'b0;
        pin(0, 1'b0);
        dev_data_fwd <= 1'b1;
        wt(1);
        dev_data_fwd <= 1'b0;
        pin(1, 1'b0);
        wt(25);
        pin(0, 1'b1);
        cfg(4, cbps_pkg::FN_ANYLED_N);
        pin(4, 1'b1);
        dev_data_fwd <= 1'b1;
        wt(1);
        dev_data_fwd <= 1'b0;
        pin(4, 1'b0);
        $display("test defaults done");
        {wr_n, rd_n} <= 2'h0;
        apb(1'b1, cbps_pkg::GPIO_OUT_OFS, 32'hF);
        apb(1'b1, cbps_pkg::GPIO_DIR_OFS, 32'hF);
        for (int c = 0; c < 13; c++)
            if (c < 6 || c > 9)
            begin
                cfg(0, c[3:0]);
                pin(0, exp0[c]);
            end
        cfg(4, 4'hB);
        pin(4, 1'b1);
        cfg(4, 4'hC);
        pin(4, 1'b1);
        cfg(2, 4'hB);
        pin(2, 1'b1);
        cfg(3, 4'hC);
        pin(3, 1'b0);
        cfg(1, 4'hB);
        pin(1, 1'b0);
        {wr_n, rd_n} <= 2'h3;
        $display("test codes done");
        apb(1'b1, cbps_pkg::CFG_OFS, 32'h0005_1A3A);
        apb(1'b1, cbps_pkg::GPIO_OUT_OFS, 32'h0);
        apb(1'b1, cbps_pkg::GPIO_DIR_OFS, 32'h1);
        ext_en <= 4'h4;
        ext_val <= 4'h4;
        wt(8);
        chk({28'h0, ctrl_pin_oe_n}, 32'h4);
        chk({31'h0, ctrl_pin_o[0]}, 32'h0);
        apb(1'b0, cbps_pkg::STATUS_OFS, 32'h0);
        chk(rd & 32'hF, 32'h6);
        apb(1'b1, cbps_pkg::GPIO_OUT_OFS, 32'h1);
        pin(0, 1'b1);
        $display("test gpio done");
        for (int c = 6; c < 10; c++)
        begin
            cfg(2, c[3:0]);
            wt(4);
            cnt();
            chk(tog, 32 >> (c - 6));
        end
        usb_suspend <= 1'b1;
        wt(4);
        cnt();
        chk(tog, 0);
        usb_suspend <= 1'b0;
        $display("test clocks done");
        final_report();
    end
endmodule
